/* File: rtl/dltss_consts.svh */
`ifndef DLTSS_CONSTS_SVH
`define DLTSS_CONSTS_SVH
`define DLTSS_ADDR_W        9
`define DLTSS_OFF_STATUS    9'h0ae
`define DLTSS_OFF_SLOT      9'h0af
`define DLTSS_OFF_MASK      9'h0b0
`define DLTSS_OFF_DATA      9'h0ad
`define DLTSS_OFF_THRESH    9'h0ab
`define DLTSS_BIT_MSG       3
`define DLTSS_BIT_EMPTY     2
`define DLTSS_BIT_NEAR      1
`define DLTSS_BIT_FULL      0
`define DLTSS_TS_UNCH       7
`define DLTSS_TS_FRM_HI     6
`define DLTSS_TS_FRM_LO     5
`define DLTSS_TS_SLOT_HI    4
`define DLTSS_RST_SLOT      8'h00
`define DLTSS_RST_MASK      8'h00
`define DLTSS_RST_THRESH    6'h00
`define DLTSS_FIFO_DEPTH    64
`endif

/* File: rtl/dltss_pkg.sv */
package dltss_pkg;
    typedef enum logic [1:0] {
        DLTSS_FRM_ALL,
        DLTSS_FRM_EVEN,
        DLTSS_FRM_ODD,
        DLTSS_FRM_BAD
    } dltss_frm_t;
    typedef enum logic [1:0] {
        DLTSS_MODE_FCS,
        DLTSS_MODE_NOFCS,
        DLTSS_MODE_PACK8,
        DLTSS_MODE_PACK6
    } dltss_mode_t;
endpackage : dltss_pkg

/* File: rtl/dltss_fifo_if.sv */
`timescale 1ns/1ps
interface dltss_fifo_if #(parameter int DEPTH = 64);
    logic                       wr_en;
    logic [7:0]                 wr_data;
    logic                       rd_en;
    logic [7:0]                 rd_data;
    logic [$clog2(DEPTH+1)-1:0] level;
    logic                       full;
    logic                       empty;
    modport owner (input wr_en, wr_data, rd_en,
                   output rd_data, level, full, empty);
    modport user  (output wr_en, wr_data, rd_en,
                   input rd_data, level, full, empty);
endinterface : dltss_fifo_if

/* File: rtl/dltss_fifo.sv */
`timescale 1ns/1ps
`include "dltss_consts.svh"
module dltss_fifo #(
    parameter int DEPTH = `DLTSS_FIFO_DEPTH
) (
    input wire logic  sys_clk,
    input wire logic  resetn,
    dltss_fifo_if.owner f
);
    import dltss_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    logic [7:0]    mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [LW-1:0] level;
    logic          do_wr;
    logic          do_rd;

    // a write into a full fifo is dropped, never stored
    assign do_wr = f.wr_en && (level != LW'(DEPTH));
    assign do_rd = f.rd_en && (level != '0);

    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= f.wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            level <= level + LW'(do_wr) - LW'(do_rd);
        end
    end

    assign f.rd_data = mem[rd_ptr];
    assign f.level   = level;
    assign f.full    = (level == LW'(DEPTH));
    assign f.empty   = (level == '0);

    a_full_drop : assert property (@(posedge sys_clk) disable iff (!resetn)
        f.full && f.wr_en && !f.rd_en |=> f.full && $stable(level))
        else $error("write into full fifo changed level");
endmodule : dltss_fifo

/* File: rtl/dltss_link_status.sv */
`timescale 1ns/1ps
`include "dltss_consts.svh"
// Function
// - message flag high between opening and closing flags
// - message flag low during idle or abort
// - unformatted or circular mode: message flag high
// - empty flag one when fifo empty
// - near-empty flag and pulse after threshold byte
// - near-empty holds until refill to threshold or above
// - writes to full fifo are discarded
// - after overflow, flag held until fifo drains; abort left to formatter
// - slot bit seven unchannelized, test only
// - frame select: all, even, odd, invalid
// - host bypasses overhead insertion for own bits
// - five-bit slot field, zero is framing bit in t1 mode
// - eight-bit mask enables slot bits
// - mask lsb is first bit in slot
// - mask ignored on t1 framing bit
// - six-bit threshold, zero disables near-empty
// - transmit fifo holds 64 bytes
module dltss_link_status #(
    parameter int DEPTH = `DLTSS_FIFO_DEPTH
) (
    input  wire logic                      sys_clk,
    input  wire logic                      resetn,
    input  wire logic [`DLTSS_ADDR_W-1:0]  host_addr,
    input  wire logic                      host_wr,
    input  wire logic                      host_rd,
    input  wire logic [7:0]                host_wdata,
    output logic      [7:0]                host_rdata,
    input  wire dltss_pkg::dltss_mode_t    link_mode,
    input  wire logic                      circular_mode,
    input  wire logic                      tx_enable,
    input  wire logic                      t1_mode,
    input  wire logic                      tx_bit_req,
    input  wire logic                      frame_odd,
    input  wire logic [4:0]                slot_num,
    input  wire logic [2:0]                bit_num,
    input  wire logic                      hdlc_in_message,
    input  wire logic                      hdlc_byte_take,
    output logic      [7:0]                tx_byte,
    output logic                           tx_byte_valid,
    output logic                           link_bit_select,
    output logic                           tx_near_empty_irq,
    output logic                           tx_fifo_overflowed
);
    import dltss_pkg::*;
    localparam int LW = $clog2(DEPTH+1);

    dltss_fifo_if #(.DEPTH(DEPTH)) fif ();

    dltss_fifo #(.DEPTH(DEPTH)) u_fifo (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .f       (fif.owner)
    );

    logic [7:0] secondary_link_slot_select;
    logic [7:0] secondary_link_bit_mask;
    logic [5:0] near_empty_threshold;
    logic       tx_fifo_near_empty_flag;
    logic       tx_msg_active_flag;
    logic       unformatted;
    logic       below_thresh;
    logic       frame_ok;
    logic       slot_ok;
    logic       fbit_sel;
    dltss_frm_t frm_sel;

    // registers written over the host port
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            secondary_link_slot_select <= `DLTSS_RST_SLOT;
            secondary_link_bit_mask    <= `DLTSS_RST_MASK;
            near_empty_threshold       <= `DLTSS_RST_THRESH;
        end else if (host_wr) begin
            if (host_addr == `DLTSS_OFF_SLOT) begin
                secondary_link_slot_select <= host_wdata;
            end
            if (host_addr == `DLTSS_OFF_MASK) begin
                secondary_link_bit_mask <= host_wdata;
            end
            if (host_addr == `DLTSS_OFF_THRESH) begin
                near_empty_threshold <= host_wdata[5:0];
            end
        end
    end

    // fifo fill and drain
    assign fif.wr_en   = host_wr && (host_addr == `DLTSS_OFF_DATA);
    assign fif.wr_data = host_wdata;
    assign fif.rd_en   = tx_enable && hdlc_byte_take && !fif.empty;
    assign tx_byte       = fif.rd_data;
    assign tx_byte_valid = !fif.empty;

    // overflow sticky until fifo drains; abort then left to the formatter
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_fifo_overflowed <= 1'b0;
        end else if (fif.wr_en && fif.full) begin
            tx_fifo_overflowed <= 1'b1;
        end else if (fif.empty) begin
            tx_fifo_overflowed <= 1'b0;
        end
    end

    // message activity
    assign unformatted = (link_mode == DLTSS_MODE_PACK8)
                      || (link_mode == DLTSS_MODE_PACK6);
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_msg_active_flag <= 1'b0;
        end else if (unformatted || circular_mode) begin
            tx_msg_active_flag <= 1'b1;
        end else begin
            // formatter low during flags and aborts
            tx_msg_active_flag <= hdlc_in_message;
        end
    end

    // near-empty: level strictly under threshold counts as emptied past it
    assign below_thresh = (fif.level < LW'(near_empty_threshold));
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_fifo_near_empty_flag <= 1'b0;
            tx_near_empty_irq       <= 1'b0;
        end else begin
            tx_near_empty_irq <= 1'b0;
            if (near_empty_threshold == 6'h00) begin
                tx_fifo_near_empty_flag <= 1'b0;
            end else if (!tx_fifo_near_empty_flag && below_thresh) begin
                tx_fifo_near_empty_flag <= 1'b1;
                tx_near_empty_irq       <= 1'b1;
            end else if (tx_fifo_near_empty_flag && !below_thresh) begin
                tx_fifo_near_empty_flag <= 1'b0;
            end
        end
    end

    // register reads: pure mux, no side effects
    always_comb begin
        host_rdata = 8'h00;
        if (host_rd) begin
            unique case (host_addr)
                `DLTSS_OFF_STATUS: begin
                    host_rdata[`DLTSS_BIT_MSG]   = tx_msg_active_flag;
                    host_rdata[`DLTSS_BIT_EMPTY] = fif.empty;
                    host_rdata[`DLTSS_BIT_NEAR]  = tx_fifo_near_empty_flag;
                    host_rdata[`DLTSS_BIT_FULL]  = fif.full;
                end
                `DLTSS_OFF_SLOT:   host_rdata = secondary_link_slot_select;
                `DLTSS_OFF_MASK:   host_rdata = secondary_link_bit_mask;
                `DLTSS_OFF_THRESH: host_rdata = {2'b00, near_empty_threshold};
                default:           host_rdata = 8'h00;
            endcase
        end
    end

    // slot and bit selection for the secondary link
    assign frm_sel = dltss_frm_t'(
        secondary_link_slot_select[`DLTSS_TS_FRM_HI:`DLTSS_TS_FRM_LO]);
    always_comb begin
        unique case (frm_sel)
            DLTSS_FRM_ALL:  frame_ok = 1'b1;
            DLTSS_FRM_EVEN: frame_ok = !frame_odd;
            DLTSS_FRM_ODD:  frame_ok = frame_odd;
            DLTSS_FRM_BAD:  frame_ok = 1'b0;
        endcase
    end
    // test-only unchannelized mode takes every slot
    assign slot_ok = secondary_link_slot_select[`DLTSS_TS_UNCH]
        || (slot_num == secondary_link_slot_select[`DLTSS_TS_SLOT_HI:0]);
    // overhead is inserted downstream of this selection
    assign fbit_sel = t1_mode
        && (secondary_link_slot_select[`DLTSS_TS_SLOT_HI:0] == 5'h00)
        && !secondary_link_slot_select[`DLTSS_TS_UNCH];
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            link_bit_select <= 1'b0;
        end else begin
            link_bit_select <= tx_bit_req && frame_ok && slot_ok
                && (fbit_sel || secondary_link_bit_mask[bit_num]);
        end
    end

    a_near_set : assert property (@(posedge sys_clk) disable iff (!resetn)
        (near_empty_threshold != 6'h00) && !tx_fifo_near_empty_flag
        && below_thresh |=> tx_fifo_near_empty_flag && tx_near_empty_irq)
        else $error("near-empty not raised");
    a_near_hold : assert property (@(posedge sys_clk) disable iff (!resetn)
        tx_fifo_near_empty_flag && below_thresh
        && $stable(near_empty_threshold) |=> !tx_near_empty_irq)
        else $error("near-empty interrupt repeated");
    a_near_off : assert property (@(posedge sys_clk) disable iff (!resetn)
        near_empty_threshold == 6'h00 |=> !tx_near_empty_irq)
        else $error("near-empty raised while disabled");
    a_msg_unfmt : assert property (@(posedge sys_clk) disable iff (!resetn)
        unformatted ##1 unformatted |-> tx_msg_active_flag)
        else $error("message flag low in unformatted mode");
    a_msg_idle : assert property (@(posedge sys_clk) disable iff (!resetn)
        !unformatted && !circular_mode && !hdlc_in_message
        |=> !tx_msg_active_flag)
        else $error("message flag high while idle");
    a_msg_frame : assert property (@(posedge sys_clk) disable iff (!resetn)
        !unformatted && !circular_mode && hdlc_in_message
        |=> tx_msg_active_flag)
        else $error("message flag low in frame");
    a_bad_frame : assert property (@(posedge sys_clk) disable iff (!resetn)
        frm_sel == DLTSS_FRM_BAD |=> !link_bit_select)
        else $error("invalid frame select used");
    a_fbit_mask : assert property (@(posedge sys_clk) disable iff (!resetn)
        tx_bit_req && fbit_sel && frame_ok && slot_ok |=> link_bit_select)
        else $error("mask applied to framing bit");
    a_mask_bit : assert property (@(posedge sys_clk) disable iff (!resetn)
        tx_bit_req && !fbit_sel && !secondary_link_bit_mask[bit_num]
        |=> !link_bit_select)
        else $error("masked bit selected");
endmodule : dltss_link_status

/* File: test/dltss_line_model.sv */
`timescale 1ns/1ps
// line side: random bit-time queries, half of them aimed at the chosen slot
module dltss_line_model (
    input  wire logic       sys_clk,
    input  wire logic       run,
    input  wire logic [4:0] pick_slot,
    output logic            tx_bit_req,
    output logic            frame_odd,
    output logic [4:0]      slot_num,
    output logic [2:0]      bit_num
);
    always @(negedge sys_clk) begin
        tx_bit_req <= run & 1'($urandom);
        frame_odd  <= 1'($urandom);
        slot_num   <= 1'($urandom) ? pick_slot : 5'($urandom);
        bit_num    <= 3'($urandom);
    end
endmodule : dltss_line_model

/* File: test/tb.sv */
`timescale 1ns/1ps
`include "dltss_consts.svh"
module tb;
    import dltss_pkg::*;
    logic                     sys_clk = 1'b0;
    logic                     resetn = 1'b0;
    logic [`DLTSS_ADDR_W-1:0] host_addr = '0;
    logic                     host_wr = 1'b0, host_rd = 1'b0;
    logic [7:0]               host_wdata = 8'h00, host_rdata, tx_byte;
    dltss_mode_t              link_mode = DLTSS_MODE_FCS;
    logic                     circular_mode = 1'b0, t1_mode = 1'b0;
    logic                     tx_enable = 1'b1;
    logic                     hdlc_in_message = 1'b0, hdlc_byte_take = 1'b0;
    logic                     run = 1'b0, lk_on = 1'b0;
    logic                     tx_bit_req, frame_odd, tx_byte_valid;
    logic                     link_bit_select, tx_near_empty_irq;
    logic                     tx_fifo_overflowed;
    logic [4:0]               slot_num;
    logic [2:0]               bit_num;
    logic [7:0]               slot_reg = 8'h00, mask_reg = 8'h00;
    logic [7:0]               q[$];
    int                       err_count = 0, total_checks = 0, irq_n = 0;

    always #5 sys_clk = ~sys_clk;

    dltss_link_status dut (.sys_clk(sys_clk), .resetn(resetn),
        .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata(host_rdata),
        .link_mode(link_mode), .circular_mode(circular_mode),
        .tx_enable(tx_enable), .t1_mode(t1_mode), .tx_bit_req(tx_bit_req),
        .frame_odd(frame_odd), .slot_num(slot_num), .bit_num(bit_num),
        .hdlc_in_message(hdlc_in_message), .hdlc_byte_take(hdlc_byte_take),
        .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
        .link_bit_select(link_bit_select),
        .tx_near_empty_irq(tx_near_empty_irq),
        .tx_fifo_overflowed(tx_fifo_overflowed));

    dltss_line_model line (.sys_clk(sys_clk), .run(run),
        .pick_slot(slot_reg[4:0]), .tx_bit_req(tx_bit_req),
        .frame_odd(frame_odd), .slot_num(slot_num), .bit_num(bit_num));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    // frame code 11 never matches; even frame means frame_odd low;
    // the t1 framing bit ignores the mask, bit seven takes every slot
    function automatic logic exp_sel();
        logic fok;
        logic fbit;
        fok = (slot_reg[6:5] == 2'b00)
            || (slot_reg[6:5] == {frame_odd, !frame_odd});
        fbit = t1_mode && (slot_reg[4:0] == 5'h00) && !slot_reg[7];
        return tx_bit_req && fok && (slot_reg[7] || slot_num == slot_reg[4:0])
            && (fbit || mask_reg[bit_num]);
    endfunction : exp_sel

    always @(negedge sys_clk)
        if (lk_on)
            chk1(link_bit_select, exp_sel());

    always @(posedge sys_clk)
        if (tx_near_empty_irq === 1'b1)
            irq_n++;

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(negedge sys_clk);
        host_wr = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        host_rd = 1'b1;
        host_addr = a;
        @(posedge sys_clk);
        chk8(host_rdata, e);
        @(negedge sys_clk);
        host_rd = 1'b0;
    endtask : rd_chk

    // fill n bytes, drain them all, watching level flags after each byte
    task automatic fill_drain(input logic [5:0] th, input int n);
        int lvl;
        wr(`DLTSS_OFF_THRESH, {2'b00, th});
        for (int i = 0; i < n; i++) begin
            q.push_back(8'($urandom));
            wr(`DLTSS_OFF_DATA, q[$]);
        end
        rd_chk(`DLTSS_OFF_STATUS, {7'h00, n == 64});
        if (n == 64) begin
            // a take while the transmitter is off must not drain
            tx_enable = 1'b0;
            hdlc_byte_take = 1'b1;
            @(negedge sys_clk);
            hdlc_byte_take = 1'b0;
            tx_enable = 1'b1;
            wr(`DLTSS_OFF_DATA, 8'h5a);
            chk1(tx_fifo_overflowed, 1'b1);
            rd_chk(`DLTSS_OFF_STATUS, 8'h01);
        end
        irq_n = 0;
        for (lvl = n - 1; lvl >= 0; lvl--) begin
            @(negedge sys_clk);
            chk1(tx_byte_valid, 1'b1);
            chk8(tx_byte, q.pop_front());
            hdlc_byte_take = 1'b1;
            @(negedge sys_clk);
            hdlc_byte_take = 1'b0;
            rd_chk(`DLTSS_OFF_STATUS,
                   {5'h00, lvl == 0, th != 0 && lvl < th, 1'b0});
        end
        repeat (2) @(negedge sys_clk);
        chk8(8'(irq_n), {7'h00, th != 0});
        chk1(tx_fifo_overflowed, 1'b0);
    endtask : fill_drain

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    initial begin
        #200us;
        err_count++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h29aa));
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        rd_chk(`DLTSS_OFF_STATUS, 8'h04);
        rd_chk(`DLTSS_OFF_SLOT, `DLTSS_RST_SLOT);
        rd_chk(`DLTSS_OFF_MASK, `DLTSS_RST_MASK);
        rd_chk(9'h1ff, 8'h00);
        wr(`DLTSS_OFF_STATUS, 8'hff);
        rd_chk(`DLTSS_OFF_STATUS, 8'h04);
        $display("test reset done");
        for (int m = 0; m < 9; m++) begin
            @(negedge sys_clk);
            link_mode = dltss_mode_t'(m[2:1]);
            hdlc_in_message = m[0] && m < 8;
            circular_mode = (m == 8);
            rd_chk(`DLTSS_OFF_STATUS,
                   {4'h0, m[2] || m[0] || m == 8, 3'b100});
        end
        circular_mode = 1'b0;
        link_mode = DLTSS_MODE_FCS;
        $display("test message flag done");
        fill_drain(6'($urandom_range(63, 1)), 64);
        fill_drain(6'h05, 5);
        fill_drain(6'h00, 7);
        $display("test fifo flags done");
        // each frame code twice, once per line standard; t1 framing bit
        // once, unchannelized test mode last
        for (int k = 0; k < 9; k++) begin
            t1_mode = k[0];
            slot_reg = {k == 8, k[2:1], 5'($urandom_range(31, k[0]))};
            if (k == 1)
                slot_reg[4:0] = 5'h00;
            mask_reg = 8'($urandom);
            wr(`DLTSS_OFF_SLOT, slot_reg);
            wr(`DLTSS_OFF_MASK, mask_reg);
            rd_chk(`DLTSS_OFF_SLOT, slot_reg);
            rd_chk(`DLTSS_OFF_MASK, mask_reg);
            run <= 1'b1;
            lk_on <= 1'b1;
            repeat (150) @(negedge sys_clk);
            run <= 1'b0;
            @(negedge sys_clk);
            lk_on <= 1'b0;
            // let the checker see lk_on low before slot_reg moves
            @(negedge sys_clk);
        end
        $display("test slot select done");
        print_verdict();
    end
endmodule : tb
